/* core/fsq_pkg.sv */
package fsq_pkg;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_QUAD_PAGE = 8'h32;
	localparam logic [7:0] OP_KB_ERASE = 8'h82;
	localparam logic [7:0] OP_4KB_ERASE = 8'h20;
	localparam logic [7:0] OP_32KB_ERASE = 8'h52;
	localparam logic [7:0] OP_64KB_ERASE = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;

	// ----------------------------------------------------------------
	// Frame bit counts, region sizes and protection level codes
	// ----------------------------------------------------------------
	localparam logic [5:0] OPC_END = 6'h08;
	localparam logic [5:0] ADDR_END = 6'h20;
	localparam logic [5:0] DATA_SAT = 6'h22;
	localparam logic [8:0] PAGE_BYTES = 9'h100;
	localparam logic [4:0] SH_1KB = 5'h0a;
	localparam logic [4:0] SH_4KB = 5'h0c;
	localparam logic [4:0] SH_32KB = 5'h0f;
	localparam logic [4:0] SH_64KB = 5'h10;
	localparam logic [4:0] SH_PAGE = 5'h08;
	localparam logic [2:0] LVL_NONE = 3'h0;
	localparam logic [2:0] LVL_ALL = 3'h7;
	localparam logic [2:0] LVL_SEC_CAP = 3'h4;

	// ----------------------------------------------------------------
	// Self-timed cycle durations
	// ----------------------------------------------------------------
	localparam int unsigned REF_CLK_MHZ = 25;
	localparam int unsigned PROG_TIME_US = 700;
	localparam int unsigned SMALL_ERASE_TIME_US = 20000;
	localparam int unsigned SECTOR_ERASE_TIME_US = 50000;
	localparam int unsigned BLOCK_ERASE_TIME_US = 150000;
	localparam int unsigned CHIP_ERASE_TIME_US = 1000000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WRITE = 3'b010,
		ST_WAIT = 3'b100
	} fsq_state_type;

	typedef struct packed {
		logic protect_granularity_bit;
		logic protect_top_bottom_bit;
		logic protect_level_bit2;
		logic protect_level_bit1;
		logic protect_level_bit0;
		logic protect_complement_bit;
	} fsq_protect_type;

	typedef struct packed {
		logic we;
		logic erase;
		logic chip;
		logic [4:0] erase_shift;
		logic [23:0] addr;
		logic [7:0] data;
	} fsq_mem_req_type;

endpackage : fsq_pkg

/* core/fsq_sequencer.sv */
`timescale 1ns/10ps
// Behaviour
// - Quad program needs quad enable bit set
// - Program/erase need write enable latch set
// - Over 256 bytes: last 256 kept
// - Under 256 bytes: only those bytes written
// - Program needs chip select on byte boundary
// - Program starts on select rise, busy held
// - Latch cleared before cycle completes
// - Protected page program is ignored
// - 82h erases containing one kilobyte sector
// - 20h erases containing four kilobyte sector
// - 52h erases containing 32 kilobyte block
// - d8h erases containing 64 kilobyte block
// - Erase address anywhere inside region valid
// - Erase needs select right after address
// - Erase starts on select rise, busy held
// - Protected region erase is ignored
// - Chip erase is 60h or c7h alone
// - Chip erase needs select after opcode
// - Chip erase only when protection fully matched
// - Page data wraps to page start
module fsq_sequencer #(
	parameter int unsigned ADDR_W = 19,
	parameter int unsigned PROG_CYCLES = fsq_pkg::PROG_TIME_US * fsq_pkg::REF_CLK_MHZ,
	parameter int unsigned SMALL_ERASE_CYCLES = fsq_pkg::SMALL_ERASE_TIME_US * fsq_pkg::REF_CLK_MHZ,
	parameter int unsigned SECTOR_ERASE_CYCLES = fsq_pkg::SECTOR_ERASE_TIME_US * fsq_pkg::REF_CLK_MHZ,
	parameter int unsigned BLOCK_ERASE_CYCLES = fsq_pkg::BLOCK_ERASE_TIME_US * fsq_pkg::REF_CLK_MHZ,
	parameter int unsigned CHIP_ERASE_CYCLES = fsq_pkg::CHIP_ERASE_TIME_US * fsq_pkg::REF_CLK_MHZ
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic data_line_0_i,
	input wire logic data_line_1_i,
	input wire logic data_line_2_i,
	input wire logic data_line_3_i,
	input wire logic quad_enable_bit_i,
	input wire fsq_pkg::fsq_protect_type protect_i,
	output logic busy_o,
	output logic write_enable_latch_o,
	output fsq_pkg::fsq_mem_req_type mem_req_o
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	if (ADDR_W < 17 || ADDR_W > 24) begin : g_bad_addr_w
		$error("ADDR_W must lie between 17 and 24");
	end
	if (PROG_CYCLES < 2 || SMALL_ERASE_CYCLES < 2 || SECTOR_ERASE_CYCLES < 2 ||
		BLOCK_ERASE_CYCLES < 2 || CHIP_ERASE_CYCLES < 2) begin : g_bad_cycles
		$error("cycle counts must be at least two");
	end

	localparam logic [24:0] MEM_SIZE = 25'(25'h1 << ADDR_W);
	localparam logic [23:0] ADDR_MASK = 24'(MEM_SIZE - 25'h1);

	// ----------------------------------------------------------------
	// Link domain: frame capture on the serial clock
	// ----------------------------------------------------------------
	logic first_q;
	logic [5:0] lk_cnt_q;
	logic [5:0] lk_now;
	logic [7:0] lk_op_q;
	logic [23:0] lk_addr_q;
	logic lk_par_q;
	logic lk_armed_q;
	logic [3:0] lk_hi_q;
	logic [7:0] lk_ptr_q;
	logic [7:0] lk_buf_q [256];
	logic [255:0] lk_mask_q;
	logic bsy_s1_q;
	logic bsy_s2_q;
	logic [3:0] nib;
	logic [7:0] op_full;
	assign nib = {data_line_3_i, data_line_2_i, data_line_1_i, data_line_0_i};
	assign op_full = {lk_op_q[6:0], data_line_0_i};
	assign lk_now = first_q ? 6'h00 : lk_cnt_q;
	// First edge of a frame is marked while select is high
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end
	// Busy level into the link domain
	always_ff @(posedge sclk_i) begin
		bsy_s1_q <= busy_o;
		bsy_s2_q <= bsy_s1_q;
	end
	// Clock count, opcode, address and nibble phase
	always_ff @(posedge sclk_i) begin
		lk_cnt_q <= (lk_now == fsq_pkg::DATA_SAT) ? fsq_pkg::DATA_SAT : lk_now + 6'h01;
		if (lk_now < fsq_pkg::OPC_END) begin
			lk_op_q <= op_full;
		end else if (lk_now < fsq_pkg::ADDR_END) begin
			lk_addr_q <= {lk_addr_q[22:0], data_line_0_i};
		end
		if (lk_now < fsq_pkg::ADDR_END) begin
			lk_par_q <= 1'b0;
		end else begin
			lk_par_q <= ~lk_par_q;
		end
	end
	// Page buffer: kept intact while a cycle is busy
	always_ff @(posedge sclk_i) begin
		if (lk_now == fsq_pkg::OPC_END - 6'h01) begin
			lk_armed_q <= (op_full == fsq_pkg::OP_QUAD_PAGE) && !bsy_s2_q;
			if ((op_full == fsq_pkg::OP_QUAD_PAGE) && !bsy_s2_q) begin
				lk_mask_q <= '0;
			end
		end
		if (lk_now == fsq_pkg::ADDR_END - 6'h01) begin
			lk_ptr_q <= {lk_addr_q[6:0], data_line_0_i};
		end
		if (lk_now >= fsq_pkg::ADDR_END && lk_armed_q) begin
			if (!lk_par_q) begin
				lk_hi_q <= nib;
			end else begin
				lk_buf_q[lk_ptr_q] <= {lk_hi_q, nib};
				lk_mask_q[lk_ptr_q] <= 1'b1;
				lk_ptr_q <= lk_ptr_q + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Select crossing into the reference domain
	// ----------------------------------------------------------------
	logic cs_s1_q;
	logic cs_s2_q;
	logic cs_s3_q;
	logic frame_end;
	// Two-stage synchroniser plus edge history
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
		end else begin
			cs_s1_q <= cs_n_i;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
		end
	end
	assign frame_end = cs_s2_q && !cs_s3_q;
	// ----------------------------------------------------------------
	// Protection check
	// ----------------------------------------------------------------
	function automatic logic prot_hit(input fsq_pkg::fsq_protect_type p, input logic [23:0] lo,
		input logic [23:0] hi);
		logic [2:0] lvl;
		logic [24:0] unit;
		logic [24:0] edge_a;
		logic in_range;
		lvl = {p.protect_level_bit2, p.protect_level_bit1, p.protect_level_bit0};
		unit = 25'h0;
		edge_a = 25'h0;
		in_range = 1'b0;
		if (p.protect_granularity_bit) begin
			unit = (lvl >= fsq_pkg::LVL_SEC_CAP) ? 25'h0008000 : 25'(25'h0001000 << 3'(lvl - 3'h1));
		end else begin
			unit = 25'(25'h0010000 << 3'(lvl - 3'h1));
		end
		if (p.protect_top_bottom_bit) begin
			edge_a = unit;
			in_range = p.protect_complement_bit ? ({1'b0, hi} >= edge_a) : ({1'b0, lo} < edge_a);
		end else begin
			edge_a = MEM_SIZE - unit;
			in_range = p.protect_complement_bit ? ({1'b0, lo} < edge_a) : ({1'b0, hi} >= edge_a);
		end
		if (lvl == fsq_pkg::LVL_NONE) begin
			in_range = p.protect_complement_bit;
		end else if (lvl == fsq_pkg::LVL_ALL) begin
			in_range = !p.protect_complement_bit;
		end
		return in_range;
	endfunction : prot_hit

	// ----------------------------------------------------------------
	// Frame decode at the end of a frame
	// ----------------------------------------------------------------
	fsq_pkg::fsq_state_type state_q;
	logic go_write_enable_command;
	logic go_prog;
	logic go_erase;
	logic is_erase;
	logic is_chip;
	logic len_ok;
	logic prot;
	logic chip_ok;
	logic [4:0] er_shift;
	logic [23:0] er_lo;
	logic [23:0] er_hi;
	logic [23:0] pg_lo;
	logic [31:0] er_cycles;
	logic [2:0] lvl_now;
	logic wel_q;
	assign lvl_now = {protect_i.protect_level_bit2, protect_i.protect_level_bit1, protect_i.protect_level_bit0};
	// Link registers are stable here: the serial clock stands while select is high
	always_comb begin
		is_erase = 1'b1;
		is_chip = 1'b0;
		er_shift = fsq_pkg::SH_4KB;
		er_cycles = 32'(SECTOR_ERASE_CYCLES);
		unique case (lk_op_q)
			fsq_pkg::OP_KB_ERASE: begin
				er_shift = fsq_pkg::SH_1KB;
				er_cycles = 32'(SMALL_ERASE_CYCLES);
			end
			fsq_pkg::OP_4KB_ERASE: begin
				er_shift = fsq_pkg::SH_4KB;
			end
			fsq_pkg::OP_32KB_ERASE: begin
				er_shift = fsq_pkg::SH_32KB;
				er_cycles = 32'(BLOCK_ERASE_CYCLES);
			end
			fsq_pkg::OP_64KB_ERASE: begin
				er_shift = fsq_pkg::SH_64KB;
				er_cycles = 32'(BLOCK_ERASE_CYCLES);
			end
			fsq_pkg::OP_CHIP_ERASE_A, fsq_pkg::OP_CHIP_ERASE_B: begin
				is_chip = 1'b1;
				er_cycles = 32'(CHIP_ERASE_CYCLES);
			end
			default: begin
				is_erase = 1'b0;
			end
		endcase
		// Any address inside the region selects it
		er_lo = lk_addr_q & ADDR_MASK & ~24'((25'h1 << er_shift) - 25'h1);
		er_hi = er_lo | 24'((25'h1 << er_shift) - 25'h1);
		pg_lo = lk_addr_q & ADDR_MASK & ~24'((25'h1 << fsq_pkg::SH_PAGE) - 25'h1);
		chip_ok = (lvl_now == fsq_pkg::LVL_NONE && !protect_i.protect_complement_bit) ||
			(lvl_now == fsq_pkg::LVL_ALL && protect_i.protect_complement_bit);
		len_ok = is_chip ? (lk_cnt_q == fsq_pkg::OPC_END) : (lk_cnt_q == fsq_pkg::ADDR_END);
		prot = is_chip ? !chip_ok : prot_hit(protect_i, er_lo, er_hi);
		go_erase = frame_end && state_q == fsq_pkg::ST_IDLE && is_erase && len_ok && wel_q && !prot;
		go_prog = frame_end && state_q == fsq_pkg::ST_IDLE && lk_op_q == fsq_pkg::OP_QUAD_PAGE &&
			lk_cnt_q == fsq_pkg::DATA_SAT && !lk_par_q && lk_armed_q && quad_enable_bit_i && wel_q &&
			!prot_hit(protect_i, pg_lo, pg_lo | 24'h0000ff);
		go_write_enable_command = frame_end && state_q == fsq_pkg::ST_IDLE && lk_op_q == fsq_pkg::OP_WRITE_ENABLE &&
			lk_cnt_q == fsq_pkg::OPC_END;
	end

	// ----------------------------------------------------------------
	// Self-timed cycle control
	// ----------------------------------------------------------------
	logic [7:0] idx_q;
	logic [31:0] wait_q;

	// Cycle state: program walks the page, then all cycles wait out their time
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			state_q <= fsq_pkg::ST_IDLE;
		end else begin
			unique case (state_q)
				fsq_pkg::ST_IDLE: begin
					if (go_prog) begin
						state_q <= fsq_pkg::ST_WRITE;
					end else if (go_erase) begin
						state_q <= fsq_pkg::ST_WAIT;
					end
				end
				fsq_pkg::ST_WRITE: begin
					if (idx_q == 8'hff) begin
						state_q <= fsq_pkg::ST_WAIT;
					end
				end
				fsq_pkg::ST_WAIT: begin
					if (wait_q == 32'h0) begin
						state_q <= fsq_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Page index and duration counter
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			idx_q <= 8'h00;
			wait_q <= 32'h0;
		end else begin
			if (go_prog) begin
				idx_q <= 8'h00;
				wait_q <= 32'(PROG_CYCLES - 1);
			end else if (go_erase) begin
				wait_q <= er_cycles - 32'h1;
			end else if (state_q == fsq_pkg::ST_WRITE) begin
				idx_q <= idx_q + 8'h01;
			end else if (state_q == fsq_pkg::ST_WAIT && wait_q != 32'h0) begin
				wait_q <= wait_q - 32'h1;
			end
		end
	end

	// Write enable latch: set by its command, cleared as a cycle starts
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			wel_q <= 1'b0;
		end else if (go_prog || go_erase) begin
			wel_q <= 1'b0;
		end else if (go_write_enable_command) begin
			wel_q <= 1'b1;
		end
	end

	// Array requests: page bytes with their mask, or one erase pulse
	logic [23:0] page_q;
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			page_q <= 24'h0;
			mem_req_o <= '0;
		end else begin
			mem_req_o <= '0;
			if (go_prog) begin
				page_q <= pg_lo;
			end
			if (go_erase) begin
				mem_req_o.erase <= 1'b1;
				mem_req_o.chip <= is_chip;
				mem_req_o.erase_shift <= er_shift;
				mem_req_o.addr <= is_chip ? 24'h0 : er_lo;
			end else if (state_q == fsq_pkg::ST_WRITE) begin
				mem_req_o.we <= lk_mask_q[idx_q];
				mem_req_o.addr <= page_q | {16'h0, idx_q};
				mem_req_o.data <= lk_buf_q[idx_q];
			end
		end
	end

	assign busy_o = state_q != fsq_pkg::ST_IDLE;
	assign write_enable_latch_o = wel_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_start;
		go_prog || go_erase;
	endsequence
	sequence s_busy_hold;
		busy_o [*2];
	endsequence
	sequence s_walk_start;
		$rose(state_q == fsq_pkg::ST_WRITE);
	endsequence
	property p_qe_gate;
		@(posedge ref_clk_i) disable iff (!resetn_i) s_walk_start |-> $past(quad_enable_bit_i);
	endproperty
	a_qe_gate: assert property (p_qe_gate) else $error("quad program without quad enable");
	property p_wel_gate;
		@(posedge ref_clk_i) disable iff (!resetn_i) $rose(busy_o) |-> $past(write_enable_latch_o);
	endproperty
	a_wel_gate: assert property (p_wel_gate) else $error("cycle started without latch");
	property p_byte_bound;
		@(posedge ref_clk_i) disable iff (!resetn_i)
			s_walk_start |-> $past(!lk_par_q && lk_cnt_q == fsq_pkg::DATA_SAT);
	endproperty
	a_byte_bound: assert property (p_byte_bound) else $error("program off byte boundary");
	property p_busy_start;
		@(posedge ref_clk_i) disable iff (!resetn_i) s_start |=> s_busy_hold;
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy not held after start");
	property p_wel_clear;
		@(posedge ref_clk_i) disable iff (!resetn_i) s_start |=> !write_enable_latch_o && busy_o;
	endproperty
	a_wel_clear: assert property (p_wel_clear) else $error("latch not cleared during cycle");
	property p_erase_align;
		@(posedge ref_clk_i) disable iff (!resetn_i)
			mem_req_o.erase && !mem_req_o.chip |->
			(mem_req_o.addr & 24'((25'h1 << mem_req_o.erase_shift) - 25'h1)) == 24'h0;
	endproperty
	a_erase_align: assert property (p_erase_align) else $error("erase base not aligned");
	property p_erase_len;
		@(posedge ref_clk_i) disable iff (!resetn_i)
			mem_req_o.erase |-> $past(lk_cnt_q) == (mem_req_o.chip ? fsq_pkg::OPC_END : fsq_pkg::ADDR_END);
	endproperty
	a_erase_len: assert property (p_erase_len) else $error("erase with wrong frame length");
	property p_chip_prot;
		@(posedge ref_clk_i) disable iff (!resetn_i)
			mem_req_o.erase && mem_req_o.chip |-> $past({lvl_now, protect_i.protect_complement_bit}) inside {4'h0, 4'hf};
	endproperty
	a_chip_prot: assert property (p_chip_prot) else $error("chip erase under protection");
	property p_write_stay;
		@(posedge ref_clk_i) disable iff (!resetn_i) go_prog |=> (state_q == fsq_pkg::ST_WRITE) [*8];
	endproperty
	a_write_stay: assert property (p_write_stay) else $error("page walk cut short");
endmodule : fsq_sequencer

/* dv/fsq_host.sv */
`timescale 1ns/10ps
// Serial host model: link clock runs only inside frames
module fsq_host (
	output logic sclk_o,
	output logic cs_n_o,
	output logic [3:0] data_o
);
	// Idle link: clock still, select rises after time zero so the frame-start flag sees the edge
	initial begin
		sclk_o = 1'b0;
		data_o = 4'h5;
		#1 cs_n_o = 1'b1;
	end

	// One link clock of 48 ns carrying a group of bits
	task automatic tick(input logic [3:0] v);
		data_o = v;
		#12 sclk_o = 1'b1;
		#24 sclk_o = 1'b0;
		#12;
	endtask : tick

	// ----------------------------------------------------------------
	// Frame: opcode, optional address, quad bytes, stray clocks
	// ----------------------------------------------------------------
	task automatic frame(input logic [7:0] op, input logic [23:0] a, input bit wa, input int nb,
		input logic [7:0] sd, input int extra);
		logic [7:0] b;
		cs_n_o = 1'b0;
		#24;
		for (int i = 7; i >= 0; i--) tick({~data_o[3:1], op[i]});
		if (wa) for (int i = 23; i >= 0; i--) tick({~data_o[3:1], a[i]});
		for (int n = 0; n < nb; n++) begin
			b = sd + 8'(n >> 1);
			tick(b[7:4]);
			tick(b[3:0]);
		end
		for (int i = 0; i < extra; i++) tick(~data_o);
		// Select rises right after the last group unless stray clocks were asked for
		cs_n_o = 1'b1;
		data_o = ~data_o;
	endtask : frame
endmodule : fsq_host

/* dv/testbench.sv */
`timescale 1ns/10ps
// Self-checking bench for the program and erase sequencer
module testbench;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic quad_enable_bit_i = 1'b0;
	fsq_pkg::fsq_protect_type protect_i = '0;
	logic sclk;
	logic cs_n;
	logic [3:0] dl;
	logic busy_o;
	logic write_enable_latch_o;
	fsq_pkg::fsq_mem_req_type mem_req_o;
	fsq_pkg::fsq_mem_req_type er_last;
	logic [7:0] pg [256];
	int bad_count = 0;
	int n_tests = 0;
	int wr_cnt = 0;
	int er_cnt = 0;
	logic [7:0] eop [4] = '{fsq_pkg::OP_KB_ERASE, fsq_pkg::OP_4KB_ERASE, fsq_pkg::OP_32KB_ERASE,
		fsq_pkg::OP_64KB_ERASE};
	logic [4:0] esh [4] = '{fsq_pkg::SH_1KB, fsq_pkg::SH_4KB, fsq_pkg::SH_32KB, fsq_pkg::SH_64KB};

	// Core clock, 40 ns
	always #20 ref_clk_i = ~ref_clk_i;

	fsq_host host (
		.sclk_o(sclk),
		.cs_n_o(cs_n),
		.data_o(dl)
	);

	fsq_sequencer #(
		.PROG_CYCLES(4),
		.SMALL_ERASE_CYCLES(4),
		.SECTOR_ERASE_CYCLES(4),
		.BLOCK_ERASE_CYCLES(4),
		.CHIP_ERASE_CYCLES(4)
	) dut (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.sclk_i(sclk),
		.cs_n_i(cs_n),
		.data_line_0_i(dl[0]),
		.data_line_1_i(dl[1]),
		.data_line_2_i(dl[2]),
		.data_line_3_i(dl[3]),
		.quad_enable_bit_i(quad_enable_bit_i),
		.protect_i(protect_i),
		.busy_o(busy_o),
		.write_enable_latch_o(write_enable_latch_o),
		.mem_req_o(mem_req_o)
	);

	// Record the page writes and erase requests handed to the array
	always @(posedge ref_clk_i) begin
		if (mem_req_o.we === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
			pg[mem_req_o.addr[7:0]] <= mem_req_o.data;
		end
		if (mem_req_o.erase === 1'b1) begin
			er_cnt <= er_cnt + 1;
			er_last <= mem_req_o;
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [47:0] ex, input logic [47:0] got);
		n_tests++;
		if (got !== ex) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim

	// Status inputs change just after a core clock edge
	task automatic set_in(input logic qe, input logic [5:0] p);
		@(posedge ref_clk_i);
		#1;
		quad_enable_bit_i = qe;
		protect_i = p;
	endtask : set_in

	// Write enable frame, then the latch must read back set
	task automatic write_enable_command();
		host.frame(fsq_pkg::OP_WRITE_ENABLE, 24'h0, 1'b0, 0, 8'h0, 0);
		repeat (6) @(posedge ref_clk_i);
		#1;
		chk("latch set", 1'b1, write_enable_latch_o);
	endtask : write_enable_command

	// Send a frame and follow busy through the self-timed cycle
	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input bit wa, input int nb, input int extra,
		input logic go);
		logic seen;
		seen = 1'b0;
		wr_cnt = 0;
		er_cnt = 0;
		host.frame(op, a, wa, nb, 8'h3c, extra);
		for (int i = 0; i < 12 && !seen; i++) begin
			@(posedge ref_clk_i);
			#1;
			seen = (busy_o === 1'b1);
		end
		chk("cycle started", go, seen);
		if (seen) begin
			chk("latch in cycle", 1'b0, write_enable_latch_o);
			for (int i = 0; busy_o !== 1'b0; i++) begin
				if (i == 700) begin
					bad_count++;
					$display("ERROR busy end expected 0 seen %b", busy_o);
					end_sim();
				end
				@(posedge ref_clk_i);
				#1;
			end
			repeat (4) @(posedge ref_clk_i);
		end
	endtask : cmd

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge ref_clk_i);
		#1;
		resetn_i = 1'b1;
		chk("reset state", '0, {busy_o, write_enable_latch_o, mem_req_o});
		repeat (3) @(posedge ref_clk_i);
		set_in(1'b1, 6'h00);
		cmd(fsq_pkg::OP_QUAD_PAGE, 24'h000100, 1'b1, 2, 0, 1'b0);
		chk("no write", 0, wr_cnt);
		$display("test no latch done");
		write_enable_command();
		set_in(1'b0, 6'h00);
		cmd(fsq_pkg::OP_QUAD_PAGE, 24'h000100, 1'b1, 2, 0, 1'b0);
		chk("latch kept", 1'b1, write_enable_latch_o);
		$display("test quad off done");
		set_in(1'b1, 6'h00);
		cmd(fsq_pkg::OP_QUAD_PAGE, 24'h0012fe, 1'b1, 3, 0, 1'b1);
		chk("short count", 3, wr_cnt);
		chk("byte fe", 8'h3c, pg[8'hfe]);
		chk("wrapped byte", 8'h3d, pg[8'h00]);
		$display("test short wrap done");
		write_enable_command();
		cmd(fsq_pkg::OP_QUAD_PAGE, 24'h000300, 1'b1, 258, 0, 1'b1);
		chk("long count", 256, wr_cnt);
		chk("overwritten byte", 8'hbc, pg[8'h00]);
		chk("kept byte", 8'h3d, pg[8'h02]);
		$display("test long page done");
		write_enable_command();
		cmd(fsq_pkg::OP_QUAD_PAGE, 24'h000300, 1'b1, 4, 1, 1'b0);
		$display("test odd nibble done");
		for (int k = 0; k < 4; k++) begin
			write_enable_command();
			cmd(eop[k], 24'h012345, 1'b1, 0, 0, 1'b1);
			chk("erase count", 1, er_cnt);
			chk("erase base", 24'h012345 & ~((24'h1 << esh[k]) - 24'h1), er_last.addr);
			chk("erase size", esh[k], er_last.erase_shift);
		end
		$display("test erase kinds done");
		write_enable_command();
		cmd(fsq_pkg::OP_64KB_ERASE, 24'h012345, 1'b1, 0, 1, 1'b0);
		set_in(1'b1, 6'h0e);
		cmd(fsq_pkg::OP_QUAD_PAGE, 24'h000100, 1'b1, 2, 0, 1'b0);
		cmd(fsq_pkg::OP_4KB_ERASE, 24'h012345, 1'b1, 0, 0, 1'b0);
		cmd(fsq_pkg::OP_CHIP_ERASE_A, 24'h0, 1'b0, 0, 0, 1'b0);
		$display("test protected done");
		set_in(1'b1, 6'h00);
		cmd(fsq_pkg::OP_CHIP_ERASE_B, 24'h0, 1'b0, 0, 1, 1'b0);
		set_in(1'b1, 6'h0f);
		cmd(fsq_pkg::OP_CHIP_ERASE_A, 24'h0, 1'b0, 0, 0, 1'b1);
		chk("chip erase a", {2'b11, 24'h0}, {er_last.chip, er_last.erase, er_last.addr});
		write_enable_command();
		set_in(1'b1, 6'h00);
		cmd(fsq_pkg::OP_CHIP_ERASE_B, 24'h0, 1'b0, 0, 0, 1'b1);
		chk("chip erase b", 2'b11, {er_last.chip, er_last.erase});
		chk("chip erase b count", 1, er_cnt);
		$display("test chip erase done");
		end_sim();
	end
endmodule : testbench
